// ---- design/ufgp_params.svh ----
// named constants for the upstream flow grant policy block
`ifndef UFGP_PARAMS_SVH
`define UFGP_PARAMS_SVH
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define UFGP_US_NS 1000
`define UFGP_CLK_NS 40
`define UFGP_CYC_PER_US ((`UFGP_US_NS + `UFGP_CLK_NS - 1) / `UFGP_CLK_NS)
// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define UFGP_OFF_CTRL 8'h00
`define UFGP_OFF_POLICY 8'h04
`define UFGP_OFF_POLL_INT 8'h08
`define UFGP_OFF_POLL_JIT 8'h0C
`define UFGP_OFF_GRANT_SIZE 8'h10
`define UFGP_OFF_GRANT_INT 8'h14
`define UFGP_OFF_GRANT_JIT 8'h18
`define UFGP_OFF_GPI 8'h1C
`define UFGP_OFF_MS_BYTES 8'h20
`define UFGP_OFF_T0 8'h24
`define UFGP_OFF_EFF_POLICY 8'h28
`define UFGP_OFF_STATUS 8'h2C
`define UFGP_OFF_MINISLOTS 8'h30
`define UFGP_OFF_GRANT_CNT 8'h34
// -----------------------------------------------------------------
// fields and codes
// -----------------------------------------------------------------
`define UFGP_CTRL_EN_BIT 0
`define UFGP_CTRL_TYPE_MSB 15
`define UFGP_CTRL_TYPE_LSB 8
`define UFGP_ST_BE 8'h02
`define UFGP_ST_NRTPS 8'h03
`define UFGP_ST_RTPS 8'h04
`define UFGP_ST_UGSAD 8'h05
`define UFGP_ST_UGS 8'h06
`define UFGP_POL_DEF_MASK 32'h000001FF
`define UFGP_POL_DROP_BIT 8
`define UFGP_STAT_CFG_ERR 0
`define UFGP_STAT_GMISS 1
`define UFGP_STAT_PMISS 2
`endif

// ---- design/ufgp_pkg.sv ----
// types shared by the upstream flow grant policy block
package ufgp_pkg;
    // -------------------------------------------------------------
    // flow configuration held by software
    // -------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic [7:0] sched_type;
        logic [31:0] policy;
        logic policy_set;
        logic [31:0] poll_interval;
        logic [31:0] poll_jitter;
        logic [15:0] grant_size;
        logic [31:0] grant_interval;
        logic [31:0] grant_jitter;
        logic [6:0] grants_per_int;
        logic [15:0] minislot_bytes;
        logic [31:0] t0_offset;
    } ufgp_cfg_s;
    // -------------------------------------------------------------
    // sticky status
    // -------------------------------------------------------------
    typedef struct packed {
        logic poll_miss;
        logic grant_miss;
    } ufgp_stat_s;
    typedef logic [31:0] ufgp_word_t;
endpackage : ufgp_pkg

// ---- design/ufgp_period_gen.sv ----
// periodic nominal-time generator with a tolerated-jitter window
`timescale 1ns/1ns
`default_nettype none
module ufgp_period_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic us_tick,
    input wire logic [31:0] t0_us,
    input wire logic [31:0] interval_us,
    input wire logic [31:0] jitter_us,
    output logic nominal,
    output logic in_window
);
    logic started_reg;
    logic [31:0] count_reg;
    logic [31:0] elapsed_reg;
    logic win_reg;
    logic nom_reg;
    wire interval_ok = (interval_us != 32'h0);
    wire at_lead = (count_reg == t0_us);
    wire at_period = (count_reg == interval_us - 32'h1);
    // a nominal time falls on the microsecond tick that completes the period
    wire fire = run & us_tick & interval_ok & (started_reg ? at_period : at_lead);
    wire win_close = us_tick & (elapsed_reg >= jitter_us);
    // the period counter restarts whenever the flow stops so t0 is measured from start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            started_reg <= 1'b0;
            count_reg <= 32'h0;
            elapsed_reg <= 32'h0;
            win_reg <= 1'b0;
            nom_reg <= 1'b0;
        end
        else
        begin
            nom_reg <= fire;
            if (!run)
            begin
                started_reg <= 1'b0;
                count_reg <= 32'h0;
                win_reg <= 1'b0;
            end
            else if (fire)
            begin
                started_reg <= 1'b1;
                count_reg <= 32'h0;
                elapsed_reg <= 32'h0;
                win_reg <= 1'b1;
            end
            else if (us_tick)
            begin
                count_reg <= count_reg + 32'h1;
                if (elapsed_reg != 32'hFFFFFFFF)
                    elapsed_reg <= elapsed_reg + 32'h1;
                if (win_close)
                    win_reg <= 1'b0;
            end
        end
    end
    assign nominal = nom_reg;
    assign in_window = win_reg;
    property p_nom_opens;
        @(posedge pclk) disable iff (!presetn) nominal |-> in_window;
    endproperty
    a_nom_opens: assert property (p_nom_opens) else $error("window not open at nominal");
    property p_win_closes;
        @(posedge pclk) disable iff (!presetn) (run && win_close && !fire) |=> !in_window;
    endproperty
    a_win_closes: assert property (p_win_closes) else $error("window outlived jitter");
endmodule : ufgp_period_gen
`default_nettype wire

// ---- design/ufgp_top.sv ----
// upstream flow policy and periodic poll/grant scheduler with apb registers
//
// How it works
// - policy word is 32 bits, bit 0 lsb; defaults zero, needed beyond best effort
// - bit 8 has no effect unless scheduling type is plain grant service
// - policy bits 9 to 31 are reserved and carry nothing
// - polls fall between nominal time and nominal time plus poll jitter
// - poll jitter is a 32-bit microsecond bound after the nominal poll time
// - grant size is 16-bit bytes covering the whole frame; grants carry it
// - grant byte size is converted to a minislot count
// - grant flows get grants at t0 plus multiples of the grant interval
// - several grants per interval all lie inside that interval's window
// - grant jitter bounds the delay past nominal on the master timebase
// - plain grant service issues exactly the configured count, 0 to 127
// - activity-detect service never exceeds the configured count per interval
// - type 6 is plain grant service, type 5 adds activity detection
`timescale 1ns/1ns
`default_nettype none
`include "ufgp_params.svh"
module ufgp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [6:0] act_grants,
    output logic grant_valid,
    input wire logic grant_ready,
    output logic [15:0] grant_bytes,
    output logic [15:0] grant_minislots,
    output logic poll_valid,
    input wire logic poll_ready,
    output logic [31:0] policy_eff
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    localparam logic [4:0] DIV_LAST = 5'(`UFGP_CYC_PER_US - 1);
    ufgp_pkg::ufgp_cfg_s cfg_reg;
    ufgp_pkg::ufgp_stat_s stat_reg;
    ufgp_pkg::ufgp_word_t prdata_reg;
    ufgp_pkg::ufgp_word_t policy_eff_reg;
    logic [4:0] div_reg;
    logic us_tick_reg;
    logic [6:0] pend_reg;
    logic poll_pend_reg;
    logic [15:0] grant_cnt_reg;
    logic [15:0] minislots_reg;
    logic [15:0] bytes_reg;
    logic err_reg;
    logic g_nom;
    logic g_win;
    logic p_nom;
    logic p_win;
    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_en = access_ph & pwrite;
    wire hit_ctrl = (paddr == `UFGP_OFF_CTRL);
    wire hit_policy = (paddr == `UFGP_OFF_POLICY);
    wire hit_poll_int = (paddr == `UFGP_OFF_POLL_INT);
    wire hit_poll_jit = (paddr == `UFGP_OFF_POLL_JIT);
    wire hit_gsize = (paddr == `UFGP_OFF_GRANT_SIZE);
    wire hit_gint = (paddr == `UFGP_OFF_GRANT_INT);
    wire hit_gjit = (paddr == `UFGP_OFF_GRANT_JIT);
    wire hit_gpi = (paddr == `UFGP_OFF_GPI);
    wire hit_msb = (paddr == `UFGP_OFF_MS_BYTES);
    wire hit_t0 = (paddr == `UFGP_OFF_T0);
    wire hit_eff = (paddr == `UFGP_OFF_EFF_POLICY);
    wire hit_stat = (paddr == `UFGP_OFF_STATUS);
    wire hit_ms = (paddr == `UFGP_OFF_MINISLOTS);
    wire hit_cnt = (paddr == `UFGP_OFF_GRANT_CNT);
    wire hit_any = hit_ctrl | hit_policy | hit_poll_int | hit_poll_jit | hit_gsize |
                   hit_gint | hit_gjit | hit_gpi | hit_msb | hit_t0 | hit_eff |
                   hit_stat | hit_ms | hit_cnt;
    // zero wait states; read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = access_ph & ~hit_any;
    // -----------------------------------------------------------------
    // scheduling type and policy
    // -----------------------------------------------------------------
    // type code decode
    wire is_ugs = (cfg_reg.sched_type == `UFGP_ST_UGS);
    wire is_ugsad = (cfg_reg.sched_type == `UFGP_ST_UGSAD);
    wire is_poll = (cfg_reg.sched_type == `UFGP_ST_RTPS) |
                   (cfg_reg.sched_type == `UFGP_ST_NRTPS);
    wire grant_run = cfg_reg.enable & (is_ugs | is_ugsad);
    wire poll_run = cfg_reg.enable & is_poll;
    wire [31:0] pol_masked = cfg_reg.policy & `UFGP_POL_DEF_MASK;
    // drop bit only for plain grant
    wire [31:0] pol_eff_next = is_ugs ? pol_masked :
                               (pol_masked & ~(32'h1 << `UFGP_POL_DROP_BIT));
    wire cfg_err = cfg_reg.enable & (cfg_reg.sched_type != `UFGP_ST_BE) & ~cfg_reg.policy_set;
    // -----------------------------------------------------------------
    // grant sizing
    // -----------------------------------------------------------------
    // bytes to minislots, rounded up; a zero minislot size means one byte
    wire [16:0] ms_div = (cfg_reg.minislot_bytes == 16'h0) ? 17'h1 :
                         {1'b0, cfg_reg.minislot_bytes};
    wire [16:0] ms_num = {1'b0, cfg_reg.grant_size} + ms_div - 17'h1;
    wire [16:0] ms_quot = ms_num / ms_div;
    // -----------------------------------------------------------------
    // grant and poll issue
    // -----------------------------------------------------------------
    // activity-detect count capped by configured limit
    wire [6:0] ad_cnt = (act_grants < cfg_reg.grants_per_int) ? act_grants :
                        cfg_reg.grants_per_int;
    wire [6:0] load_cnt = is_ugs ? cfg_reg.grants_per_int : ad_cnt;
    wire g_hs = grant_valid & grant_ready;
    wire p_hs = poll_valid & poll_ready;
    wire [6:0] pend_left = pend_reg - {6'h0, g_hs};
    // a window that closes with grants still owed is a missed commitment
    wire g_close = (pend_reg != 7'h0) & ~g_win & ~g_nom;
    wire g_miss = grant_run & (g_close | (g_nom & (pend_left != 7'h0)));
    wire p_close = poll_pend_reg & ~p_win & ~p_nom;
    wire p_miss = poll_run & (p_close | (p_nom & poll_pend_reg & ~p_hs));
    // grants only inside the jitter window
    assign grant_valid = grant_run & g_win & (pend_reg != 7'h0);
    // polls only inside the jitter window
    assign poll_valid = poll_run & p_win & poll_pend_reg;
    // -----------------------------------------------------------------
    // read mux
    // -----------------------------------------------------------------
    wire [31:0] ctrl_rd = {16'h0, cfg_reg.sched_type, 7'h0, cfg_reg.enable};
    wire [31:0] stat_rd = {29'h0, stat_reg.poll_miss, stat_reg.grant_miss, err_reg};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                         hit_policy ? cfg_reg.policy :
                         hit_poll_int ? cfg_reg.poll_interval :
                         hit_poll_jit ? cfg_reg.poll_jitter :
                         hit_gsize ? {16'h0, cfg_reg.grant_size} :
                         hit_gint ? cfg_reg.grant_interval :
                         hit_gjit ? cfg_reg.grant_jitter :
                         hit_gpi ? {25'h0, cfg_reg.grants_per_int} :
                         hit_msb ? {16'h0, cfg_reg.minislot_bytes} :
                         hit_t0 ? cfg_reg.t0_offset :
                         hit_eff ? policy_eff_reg :
                         hit_stat ? stat_rd :
                         hit_ms ? {16'h0, minislots_reg} :
                         hit_cnt ? {16'h0, grant_cnt_reg} : 32'h0;
    // -----------------------------------------------------------------
    // microsecond timebase
    // -----------------------------------------------------------------
    // one enable pulse per microsecond keeps the whole block on pclk
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_reg <= 5'h0;
            us_tick_reg <= 1'b0;
        end
        else
        begin
            us_tick_reg <= (div_reg == DIV_LAST);
            div_reg <= (div_reg == DIV_LAST) ? 5'h0 : div_reg + 5'h1;
        end
    end
    // -----------------------------------------------------------------
    // configuration registers
    // -----------------------------------------------------------------
    // grant count field is seven bits wide
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg <= '0;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
            begin
                cfg_reg.enable <= pwdata[`UFGP_CTRL_EN_BIT];
                cfg_reg.sched_type <= pwdata[`UFGP_CTRL_TYPE_MSB:`UFGP_CTRL_TYPE_LSB];
            end
            if (hit_policy)
            begin
                cfg_reg.policy <= pwdata;
                cfg_reg.policy_set <= 1'b1;
            end
            if (hit_poll_int)
                cfg_reg.poll_interval <= pwdata;
            if (hit_poll_jit)
                cfg_reg.poll_jitter <= pwdata;
            if (hit_gsize)
                cfg_reg.grant_size <= pwdata[15:0];
            if (hit_gint)
                cfg_reg.grant_interval <= pwdata;
            if (hit_gjit)
                cfg_reg.grant_jitter <= pwdata;
            if (hit_gpi)
                cfg_reg.grants_per_int <= pwdata[6:0];
            if (hit_msb)
                cfg_reg.minislot_bytes <= pwdata[15:0];
            if (hit_t0)
                cfg_reg.t0_offset <= pwdata;
        end
    end
    // -----------------------------------------------------------------
    // status and derived registers
    // -----------------------------------------------------------------
    // miss flags are write-one-to-clear; a new miss in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_reg <= '0;
            err_reg <= 1'b0;
            policy_eff_reg <= 32'h0;
            minislots_reg <= 16'h0;
            bytes_reg <= 16'h0;
            prdata_reg <= 32'h0;
        end
        else
        begin
            err_reg <= cfg_err;
            policy_eff_reg <= pol_eff_next;
            minislots_reg <= ms_quot[15:0];
            bytes_reg <= cfg_reg.grant_size;
            if (setup_ph)
                prdata_reg <= rd_mux;
            stat_reg.grant_miss <= g_miss |
                (stat_reg.grant_miss & ~(wr_en & hit_stat & pwdata[`UFGP_STAT_GMISS]));
            stat_reg.poll_miss <= p_miss |
                (stat_reg.poll_miss & ~(wr_en & hit_stat & pwdata[`UFGP_STAT_PMISS]));
        end
    end
    // -----------------------------------------------------------------
    // pending grants and polls
    // -----------------------------------------------------------------
    // leftover grants are dropped when the window ends
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_reg <= 7'h0;
            poll_pend_reg <= 1'b0;
            grant_cnt_reg <= 16'h0;
        end
        else
        begin
            if (!grant_run || g_close)
                pend_reg <= 7'h0;
            else if (g_nom)
                pend_reg <= load_cnt;
            else
                pend_reg <= pend_left;
            if (!poll_run || p_close)
                poll_pend_reg <= 1'b0;
            else if (p_nom)
                poll_pend_reg <= 1'b1;
            else if (p_hs)
                poll_pend_reg <= 1'b0;
            if (g_hs)
                grant_cnt_reg <= grant_cnt_reg + 16'h1;
        end
    end
    // -----------------------------------------------------------------
    // schedule generators
    // -----------------------------------------------------------------
    // grant schedule on microsecond timebase
    ufgp_period_gen u_grant_gen (
        .pclk(pclk),
        .presetn(presetn),
        .run(grant_run),
        .us_tick(us_tick_reg),
        .t0_us(cfg_reg.t0_offset),
        .interval_us(cfg_reg.grant_interval),
        .jitter_us(cfg_reg.grant_jitter),
        .nominal(g_nom),
        .in_window(g_win)
    );
    // poll jitter bounds the poll window
    ufgp_period_gen u_poll_gen (
        .pclk(pclk),
        .presetn(presetn),
        .run(poll_run),
        .us_tick(us_tick_reg),
        .t0_us(cfg_reg.t0_offset),
        .interval_us(cfg_reg.poll_interval),
        .jitter_us(cfg_reg.poll_jitter),
        .nominal(p_nom),
        .in_window(p_win)
    );
    assign grant_bytes = bytes_reg;
    assign grant_minislots = minislots_reg;
    assign policy_eff = policy_eff_reg;
    assign prdata = prdata_reg;
    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_reserved_zero;
        policy_eff[31:9] == 23'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved policy bit set");
    property p_drop_ignored;
        !is_ugs |=> !policy_eff[`UFGP_POL_DROP_BIT];
    endproperty
    a_drop_ignored: assert property (p_drop_ignored) else $error("drop bit passed");
    property p_cfg_err;
        (cfg_reg.enable && (cfg_reg.sched_type != `UFGP_ST_BE) && !cfg_reg.policy_set)
            |=> stat_rd[`UFGP_STAT_CFG_ERR];
    endproperty
    a_cfg_err: assert property (p_cfg_err) else $error("missing policy not flagged");
    property p_ugs_exact;
        (g_nom && is_ugs && grant_run && $stable(cfg_reg.grants_per_int))
            |=> pend_reg == $past(cfg_reg.grants_per_int);
    endproperty
    a_ugs_exact: assert property (p_ugs_exact) else $error("grant count not loaded");
    property p_ad_cap;
        (g_nom && is_ugsad && grant_run)
            |=> (pend_reg <= $past(cfg_reg.grants_per_int)) && (pend_reg <= $past(act_grants));
    endproperty
    a_ad_cap: assert property (p_ad_cap) else $error("activity grants over limit");
    property p_grant_in_win;
        g_hs |-> g_win && grant_run;
    endproperty
    a_grant_in_win: assert property (p_grant_in_win) else $error("grant outside window");
    property p_poll_in_win;
        p_hs |-> p_win && poll_run;
    endproperty
    a_poll_in_win: assert property (p_poll_in_win) else $error("poll outside window");
    property p_us_period;
        us_tick_reg |-> ##25 us_tick_reg;
    endproperty
    a_us_period: assert property (p_us_period) else $error("timebase period wrong");
    property p_bytes;
        (grant_valid && $stable(cfg_reg.grant_size)) |-> grant_bytes == cfg_reg.grant_size;
    endproperty
    a_bytes: assert property (p_bytes) else $error("grant byte size wrong");
    property p_minislots;
        (grant_valid && (cfg_reg.minislot_bytes != 16'h0) && $stable(cfg_reg.grant_size) &&
         $stable(cfg_reg.minislot_bytes))
            |-> ({16'h0, grant_minislots} * {16'h0, cfg_reg.minislot_bytes})
                >= {16'h0, cfg_reg.grant_size};
    endproperty
    a_minislots: assert property (p_minislots) else $error("minislots too few");
    property p_type_gate;
        !(is_ugs || is_ugsad) |=> pend_reg == 7'h0;
    endproperty
    a_type_gate: assert property (p_type_gate) else $error("grants for wrong type");
endmodule : ufgp_top
`default_nettype wire

// ---- verification/ufgp_modem_model.sv ----
// modem-side model that accepts grants and polls
`timescale 1ns/1ns
`default_nettype none
module ufgp_modem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic [6:0] want,
    input wire logic [8:0] policy_bits,
    output logic [9:0] behave,
    output logic grant_ready,
    output logic poll_ready,
    output logic [6:0] act_grants
);
    logic tog_reg;
    // toggles every cycle so a stalling modem refuses offers on every other cycle
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            tog_reg <= 1'b0;
        else
            tog_reg <= ~tog_reg;
    // a slow modem still takes offers inside a wide jitter window
    assign grant_ready = presetn & ~(stall & tog_reg);
    assign poll_ready = grant_ready;
    assign act_grants = want;
    // -------------------------------------------------------------
    // policy obeyed by the modem; a set bit holds that behaviour back
    // -------------------------------------------------------------
    // no broadcast requests
    assign behave[0] = policy_bits[0];
    assign behave[1] = policy_bits[1];
    assign behave[2] = policy_bits[2];
    assign behave[3] = policy_bits[3];
    assign behave[4] = policy_bits[4];
    assign behave[5] = policy_bits[5];
    assign behave[6] = policy_bits[6];
    assign behave[7] = policy_bits[7];
    assign behave[8] = policy_bits[8];
    // otherwise oversize goes to primary flow
    assign behave[9] = ~policy_bits[8];
endmodule : ufgp_modem_model
`default_nettype wire

// ---- verification/ufgp_tb_top.sv ----
// self-checking bench for the upstream flow grant policy block
`timescale 1ns/1ns
`default_nettype none
module ufgp_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall;
    logic grant_valid, grant_ready, poll_valid, poll_ready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, policy_eff, x_reg;
    logic [6:0] act_grants, want;
    logic [15:0] grant_bytes, grant_minislots, r;
    logic [9:0] behave;
    logic [32:0] rq[$];
    int bq[$];
    int n_mismatch = 0;
    int total_checks = 0;
    int cnt = 0;
    int inb = 0;
    ufgp_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .act_grants, .grant_valid, .grant_ready, .grant_bytes,
        .grant_minislots, .poll_valid, .poll_ready, .policy_eff);
    ufgp_modem_model i_modem (.pclk, .presetn, .stall, .want, .grant_ready, .poll_ready,
        .act_grants, .policy_bits(policy_eff[8:0]), .behave);
    // -------------------------------------------------------------
    // clock, helpers and bus tasks
    // -------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    function automatic logic [31:0] xs();
        x_reg = x_reg ^ (x_reg << 13);
        x_reg = x_reg ^ (x_reg >> 17);
        x_reg = x_reg ^ (x_reg << 5);
        return x_reg;
    endfunction : xs
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    // holds the request until pready is seen, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    // three nominal intervals, each must carry n offers
    task automatic bursts(input int n);
        int k;
        repeat (3) bq.push_back(n);
        for (k = 0; k < 3000 && bq.size() > 0; k++)
            @(posedge pclk);
        if (bq.size() > 0)
        begin
            n_mismatch++;
            give_verdict();
        end
        $display("offer test with %0d per interval done", n);
    endtask : bursts
    // -------------------------------------------------------------
    // result watchers
    // -------------------------------------------------------------
    always @(posedge pclk)
        if (psel && penable && !pwrite && pready)
            chk("read", rq.pop_front(), {pslverr, prdata});
    // offers counted on the falling edge, away from the launching edge
    always @(negedge pclk)
    begin
        if ((grant_valid && grant_ready) || (poll_valid && poll_ready))
            cnt++;
        if (!(grant_valid || poll_valid) && inb != 0)
        begin
            chk("offers", 33'(bq.pop_front()), 33'(cnt));
            cnt = 0;
        end
        inb = int'(grant_valid || poll_valid);
    end
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        x_reg = 32'h00004F35;
        presetn = 1'b0;
        {psel, penable, pwrite, stall} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        want = 7'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h00, 33'h0);
        rd(8'h3C, {1'b1, 32'h0});
        wr(8'h00, 32'h00000401);
        rd(8'h2C, 33'h1);
        wr(8'h04, 32'hFFFFFFFF);
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h4);
        wr(8'h0C, 32'h1);
        wr(8'h00, 32'h00000401);
        // registered outputs follow the write one edge later
        @(posedge pclk);
        chk("policy_eff", 33'hFF, {1'b0, policy_eff});
        chk("behave", 33'h2FF, {23'h0, behave});
        bursts(1);
        wr(8'h00, 32'h0);
        r = 16'(xs());
        wr(8'h10, {16'h0, r});
        wr(8'h20, 32'h10);
        wr(8'h14, 32'h4);
        wr(8'h18, 32'h2);
        wr(8'h1C, 32'h2);
        wr(8'h00, 32'h00000601);
        @(posedge pclk);
        chk("policy_eff", 33'h1FF, {1'b0, policy_eff});
        chk("behave", 33'h1FF, {23'h0, behave});
        chk("grant_bytes", {17'h0, r}, {17'h0, grant_bytes});
        chk("minislots", ({17'h0, r} + 33'hF) >> 4, {17'h0, grant_minislots});
        bursts(2);
        wr(8'h00, 32'h0);
        wr(8'h1C, 32'h3);
        wr(8'h18, 32'h3);
        want <= 7'h01;
        stall <= 1'b1;
        wr(8'h00, 32'h00000501);
        @(posedge pclk);
        chk("policy_eff", 33'hFF, {1'b0, policy_eff});
        chk("behave", 33'h2FF, {23'h0, behave});
        bursts(1);
        give_verdict();
    end
endmodule : ufgp_tb_top
`default_nettype wire
